// ===== rtl/scap_slot_cap.sv
// Summary of operation
// - Write-once slot number in bits 31:19
// - Write-once two-bit power scale, bits 16:15
// - Write-once eight-bit power value, bits 14:7
// - Write-once hot-plug capable flag, bit 6
// - Surprise removal bit 5 reads zero
// - Write-once power indicator present, bit 4
// - Write-once attention indicator present, bit 3
// - Write-once latch sensor present, bit 2
// - Write-once power controller present, bit 1
// - Write-once attention button present, bit 0
`timescale 1ns/1ps
`default_nettype none
`include "scap_cfg.svh"

module scap_slot_cap #(
    parameter int ADDR_W = 12
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              cfg_wr,
    input  wire logic              cfg_rd,
    input  wire logic [ADDR_W-1:0] cfg_addr,
    input  wire logic [3:0]        cfg_be,
    input  wire logic [31:0]       cfg_wdata,
    output logic      [31:0]       cfg_rdata,
    output logic                   cfg_rd_valid,
    output logic      [12:0]       physical_slot_number,
    output logic      [1:0]        power_limit_scale,
    output logic      [7:0]        power_limit_value,
    output logic                   hotplug_capable,
    output logic                   surprise_removal_flag,
    output logic                   power_indicator_present,
    output logic                   attention_indicator_present,
    output logic                   latch_sensor_present,
    output logic                   power_controller_present,
    output logic                   attention_button_present,
    output logic                   fields_locked
);

    localparam int NF = `SCAP_NUM_FIELDS;

    localparam logic [31:0] FIELD_MASK [NF] = '{
        `SCAP_SLOT_MASK,
        `SCAP_PLS_MASK,
        `SCAP_PLV_MASK,
        `SCAP_HOTPLUG_MASK,
        `SCAP_PWRIND_MASK,
        `SCAP_ATTIND_MASK,
        `SCAP_LSP_MASK,
        `SCAP_PWRCTL_MASK,
        `SCAP_BUTTON_MASK
    };

    generate
        if (ADDR_W < 8) begin : g_bad_addr
            $error("scap_slot_cap: ADDR_W too narrow to reach the register");
        end
    endgenerate

    scap_pkg::scap_bank_s  state;
    scap_pkg::scap_bank_s  next_state;

    logic                  reg_sel;
    logic                  reg_wr;
    logic [31:0]           lane_mask;
    scap_pkg::scap_word_t  image;
    logic [NF-1:0]         fld_locked;
    logic [31:0]           fld_value [NF];

    assign reg_sel   = (cfg_addr == ADDR_W'(`SCAP_OFFSET));
    assign reg_wr    = cfg_wr && reg_sel;
    assign lane_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_field
            scap_field_if fif ();

            assign fif.wr_en     = reg_wr;
            assign fif.wdata     = cfg_wdata;
            assign fif.lane_mask = lane_mask;
            assign fld_value[gi]  = fif.value;
            assign fld_locked[gi] = fif.locked;

            scap_wo_field #(
                .MASK (FIELD_MASK[gi])
            ) u_field (
                .core_clk (core_clk),
                .rst_b    (rst_b),
                .fld      (fif.field)
            );
        end
    endgenerate

    // Fields have disjoint masks, so OR-ing them builds the word;
    // reserved bits 18:17 and the surprise bit 5 stay zero.
    always_comb begin
        image = `SCAP_RESET;
        for (int k = 0; k < NF; k++) begin
            image = image | fld_value[k];
        end
        image[`SCAP_SRF_BIT] = 1'b0;
    end

    assign physical_slot_number        = image[`SCAP_SLOT_HI:`SCAP_SLOT_LO];
    assign power_limit_scale           = image[`SCAP_PLS_HI:`SCAP_PLS_LO];
    assign power_limit_value           = image[`SCAP_PLV_HI:`SCAP_PLV_LO];
    assign hotplug_capable             = image[`SCAP_HOTPLUG_BIT];
    assign surprise_removal_flag       = 1'b0;
    assign power_indicator_present     = image[`SCAP_PWRIND_BIT];
    assign attention_indicator_present = image[`SCAP_ATTIND_BIT];
    assign latch_sensor_present        = image[`SCAP_LSP_BIT];
    assign power_controller_present    = image[`SCAP_PWRCTL_BIT];
    assign attention_button_present    = image[`SCAP_BUTTON_BIT];
    assign fields_locked               = &fld_locked;

    // A read in the same cycle as a write returns the old word;
    // unmapped offsets answer with zero so software sees no stale data.
    always_comb begin
        next_state          = state;
        next_state.rd_valid = cfg_rd;
        if (cfg_rd) begin
            next_state.rdata = reg_sel ? image : 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state.rdata    <= 32'h0000_0000;
            state.rd_valid <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign cfg_rdata    = state.rdata;
    assign cfg_rd_valid = state.rd_valid;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_held(logic hit, logic lk, logic [31:0] v);
        hit && lk |=> $stable(v);
    endproperty

    // A field is spent by any enabled lane that it overlaps,
    // even when its other lane stays off
    logic hit_slot;
    logic hit_pls;
    logic hit_plv;
    logic hit_b0;

    assign hit_slot = reg_wr && (cfg_be[3] || cfg_be[2]);
    assign hit_pls  = reg_wr && (cfg_be[2] || cfg_be[1]);
    assign hit_plv  = reg_wr && (cfg_be[1] || cfg_be[0]);
    assign hit_b0   = reg_wr && cfg_be[0];

    chk_slot_num_held: assert property (
        p_held(hit_slot, fld_locked[0], {19'h0, physical_slot_number}))
        else $error("slot number changed after first write");

    chk_slot_num_load: assert property (
        reg_wr && (cfg_be[3:2] == 2'h3) && !fld_locked[0]
        |=> physical_slot_number == $past(cfg_wdata[31:19]))
        else $error("slot number did not take first write");

    chk_scale_held: assert property (
        p_held(hit_pls, fld_locked[1], {30'h0, power_limit_scale}))
        else $error("power scale changed after first write");

    chk_value_load: assert property (
        reg_wr && (cfg_be[1:0] == 2'h3) && !fld_locked[2]
        |=> power_limit_value == $past(cfg_wdata[14:7])
            ##1 $stable(power_limit_value))
        else $error("power value did not take first write");

    chk_value_held: assert property (
        p_held(hit_plv, fld_locked[2], {24'h0, power_limit_value}))
        else $error("power value changed after first write");

    chk_hotplug_held: assert property (
        p_held(hit_b0, fld_locked[3], {31'h0, hotplug_capable}))
        else $error("hot-plug flag changed after first write");

    chk_surprise_zero: assert property (
        cfg_rd_valid |-> !cfg_rdata[`SCAP_SRF_BIT] && !cfg_rdata[18] && !cfg_rdata[17])
        else $error("surprise or reserved bit read as one");

    chk_pwr_ind_held: assert property (
        p_held(hit_b0, fld_locked[4], {31'h0, power_indicator_present}))
        else $error("power indicator flag changed after first write");

    chk_att_ind_held: assert property (
        p_held(hit_b0, fld_locked[5], {31'h0, attention_indicator_present}))
        else $error("attention indicator flag changed after first write");

    chk_latch_held: assert property (
        p_held(hit_b0, fld_locked[6], {31'h0, latch_sensor_present}))
        else $error("latch sensor flag changed after first write");

    chk_pwr_ctl_held: assert property (
        p_held(hit_b0, fld_locked[7], {31'h0, power_controller_present}))
        else $error("power controller flag changed after first write");

    chk_button_load: assert property (
        hit_b0 && !fld_locked[8]
        |=> attention_button_present == $past(cfg_wdata[0])
            ##1 $stable(attention_button_present))
        else $error("attention button flag wrong after first write");

    chk_button_held: assert property (
        p_held(hit_b0, fld_locked[8], {31'h0, attention_button_present}))
        else $error("attention button flag changed after first write");

    chk_read_answer: assert property (
        cfg_rd && reg_sel |=> cfg_rd_valid && cfg_rdata == $past(image))
        else $error("read did not return stored word");

    chk_unmapped_zero: assert property (
        cfg_rd && !reg_sel |=> cfg_rd_valid && cfg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    chk_valid_pulse: assert property (
        !cfg_rd |=> !cfg_rd_valid)
        else $error("read answer without request");

    chk_rdata_holds: assert property (
        !cfg_rd |=> $stable(cfg_rdata))
        else $error("read data moved without a read");

    // Loads of the scale, slot number and one-bit fields; the first write touching a field decides it
    chk_scale_load: assert property (
        reg_wr && (cfg_be[2:1] == 2'h3) && !fld_locked[1]
        |=> power_limit_scale == $past(cfg_wdata[16:15]))
        else $error("power scale did not take first write");

    chk_scale_partial: assert property (
        reg_wr && (cfg_be[2:1] == 2'h2) && !fld_locked[1]
        |=> power_limit_scale[0] == 1'b0)
        else $error("power scale loaded a disabled lane");

    chk_slot_partial: assert property (
        reg_wr && (cfg_be[3:2] == 2'h1) && !fld_locked[0]
        |=> physical_slot_number[12:5] == 8'h00)
        else $error("slot number loaded a disabled lane");

    chk_hotplug_load: assert property (
        hit_b0 && !fld_locked[3]
        |=> hotplug_capable == $past(cfg_wdata[6]))
        else $error("hot-plug flag did not take first write");

    chk_pwr_ind_load: assert property (
        hit_b0 && !fld_locked[4]
        |=> power_indicator_present == $past(cfg_wdata[4]))
        else $error("power indicator flag did not take first write");

    chk_att_ind_load: assert property (
        hit_b0 && !fld_locked[5]
        |=> attention_indicator_present == $past(cfg_wdata[3]))
        else $error("attention indicator flag did not take first write");

    chk_latch_load: assert property (
        hit_b0 && !fld_locked[6]
        |=> latch_sensor_present == $past(cfg_wdata[2]))
        else $error("latch sensor flag did not take first write");

    chk_pwr_ctl_load: assert property (
        hit_b0 && !fld_locked[7]
        |=> power_controller_present == $past(cfg_wdata[1]))
        else $error("power controller flag did not take first write");

    chk_surprise_port: assert property (
        !surprise_removal_flag)
        else $error("surprise removal flag driven high");

    // Only a write to this offset may move the word or spend a field
    chk_idle_frozen: assert property (
        !reg_wr |=> $stable(image) && $stable(fld_locked))
        else $error("word changed without a write to it");

    chk_full_locks: assert property (
        reg_wr && cfg_be == 4'hF |=> fields_locked)
        else $error("full write left a field unlocked");

    chk_lock_kept: assert property (
        fields_locked |=> fields_locked)
        else $error("lock dropped without reset");

    cov_unmapped_read: cover property (
        cfg_rd && !reg_sel ##1 cfg_rd_valid);

    cov_full_write: cover property (
        reg_wr && cfg_be == 4'hF && !fld_locked[0] ##1 fields_locked);

    cov_second_write: cover property (
        reg_wr && fields_locked ##1 cfg_rd && reg_sel ##1 cfg_rd_valid);

    cov_split_write: cover property (
        reg_wr && cfg_be == 4'h3 ##[1:4] reg_wr && cfg_be == 4'hC);

    cov_read_write_same: cover property (
        reg_wr && cfg_rd);

endmodule : scap_slot_cap

`default_nettype wire

// ===== rtl/scap_cfg.svh
`ifndef SCAP_CFG_SVH
`define SCAP_CFG_SVH

// Configuration offset of the slot capabilities word
`define SCAP_OFFSET          12'h080
`define SCAP_RESET           32'h0000_0000

// Field positions
`define SCAP_SLOT_HI         31
`define SCAP_SLOT_LO         19
`define SCAP_PLS_HI          16
`define SCAP_PLS_LO          15
`define SCAP_PLV_HI          14
`define SCAP_PLV_LO          7
`define SCAP_HOTPLUG_BIT     6
`define SCAP_SRF_BIT         5
`define SCAP_PWRIND_BIT      4
`define SCAP_ATTIND_BIT      3
`define SCAP_LSP_BIT         2
`define SCAP_PWRCTL_BIT      1
`define SCAP_BUTTON_BIT      0

// Field masks, one per write-once field
`define SCAP_NUM_FIELDS      9
`define SCAP_SLOT_MASK       32'hFFF8_0000
`define SCAP_PLS_MASK        32'h0001_8000
`define SCAP_PLV_MASK        32'h0000_7F80
`define SCAP_HOTPLUG_MASK    32'h0000_0040
`define SCAP_PWRIND_MASK     32'h0000_0010
`define SCAP_ATTIND_MASK     32'h0000_0008
`define SCAP_LSP_MASK        32'h0000_0004
`define SCAP_PWRCTL_MASK     32'h0000_0002
`define SCAP_BUTTON_MASK     32'h0000_0001

`endif

// ===== rtl/scap_pkg.sv
package scap_pkg;

    typedef struct packed {
        logic [31:0] value;
        logic        locked;
    } scap_field_s;

    typedef struct packed {
        logic [31:0] rdata;
        logic        rd_valid;
    } scap_bank_s;

    typedef logic [31:0] scap_word_t;

endpackage : scap_pkg

// ===== rtl/scap_field_if.sv
`timescale 1ns/1ps
`default_nettype none

interface scap_field_if;
    logic        wr_en;
    logic [31:0] wdata;
    logic [31:0] lane_mask;
    logic [31:0] value;
    logic        locked;

    modport field (
        input  wr_en,
        input  wdata,
        input  lane_mask,
        output value,
        output locked
    );

    modport bank (
        output wr_en,
        output wdata,
        output lane_mask,
        input  value,
        input  locked
    );
endinterface : scap_field_if

`default_nettype wire

// ===== rtl/scap_wo_field.sv
`timescale 1ns/1ps
`default_nettype none
`include "scap_cfg.svh"

module scap_wo_field #(
    parameter logic [31:0] MASK = 32'h0000_0001
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    scap_field_if.field      fld
);

    scap_pkg::scap_field_s state;
    scap_pkg::scap_field_s next_state;

    logic                    hit;

    generate
        if (MASK == 32'h0000_0000) begin : g_bad_mask
            $error("scap_wo_field: empty field mask");
        end
    endgenerate

    // A write that touches any byte of the field spends its one chance
    assign hit = fld.wr_en && (|(fld.lane_mask & MASK));

    always_comb begin
        next_state = state;
        if (hit && !state.locked) begin
            next_state.value  = (state.value & ~(fld.lane_mask & MASK))
                              | (fld.wdata & fld.lane_mask & MASK);
            next_state.locked = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state.value  <= `SCAP_RESET;
            state.locked <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign fld.value  = state.value;
    assign fld.locked = state.locked;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_locked_frozen: assert property (
        state.locked |=> $stable(state.value) && state.locked)
        else $error("write-once field changed after lock");

    chk_first_write_lands: assert property (
        hit && !state.locked |=> state.locked
            && ((state.value & $past(fld.lane_mask) & MASK)
                == ($past(fld.wdata) & $past(fld.lane_mask) & MASK)))
        else $error("first write did not land in field");

    chk_mask_confined: assert property (
        (state.value & ~MASK) == 32'h0000_0000)
        else $error("field holds bits outside its mask");

endmodule : scap_wo_field

`default_nettype wire

// ===== verification/tb_scap_slot_cap.sv
`timescale 1ns/1ps
`default_nettype none
`include "scap_cfg.svh"

module tb_scap_slot_cap;
    logic        core_clk;
    logic        rst_b;
    logic        cfg_wr;
    logic        cfg_rd;
    logic [11:0] cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic        cfg_rd_valid;
    logic [12:0] physical_slot_number;
    logic [1:0]  power_limit_scale;
    logic [7:0]  power_limit_value;
    logic        hotplug_capable;
    logic        surprise_removal_flag;
    logic        power_indicator_present;
    logic        attention_indicator_present;
    logic        latch_sensor_present;
    logic        power_controller_present;
    logic        attention_button_present;
    logic        fields_locked;
    int          failures;
    int          n_tests;
    logic [31:0] word;
    logic [31:0] exp_rd;
    logic [8:0]  lock;
    logic [31:0] fmask [9] = '{`SCAP_SLOT_MASK, `SCAP_PLS_MASK, `SCAP_PLV_MASK,
                               `SCAP_HOTPLUG_MASK, `SCAP_PWRIND_MASK, `SCAP_ATTIND_MASK,
                               `SCAP_LSP_MASK, `SCAP_PWRCTL_MASK, `SCAP_BUTTON_MASK};

    scap_slot_cap #(.ADDR_W(12)) scap_slot_cap_inst (
        .core_clk                    (core_clk),
        .rst_b                       (rst_b),
        .cfg_wr                      (cfg_wr),
        .cfg_rd                      (cfg_rd),
        .cfg_addr                    (cfg_addr),
        .cfg_be                      (cfg_be),
        .cfg_wdata                   (cfg_wdata),
        .cfg_rdata                   (cfg_rdata),
        .cfg_rd_valid                (cfg_rd_valid),
        .physical_slot_number        (physical_slot_number),
        .power_limit_scale           (power_limit_scale),
        .power_limit_value           (power_limit_value),
        .hotplug_capable             (hotplug_capable),
        .surprise_removal_flag       (surprise_removal_flag),
        .power_indicator_present     (power_indicator_present),
        .attention_indicator_present (attention_indicator_present),
        .latch_sensor_present        (latch_sensor_present),
        .power_controller_present    (power_controller_present),
        .attention_button_present    (attention_button_present),
        .fields_locked               (fields_locked)
    );

    always #10 core_clk = ~core_clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check_all(input logic v);
        check("rd_valid", {31'h0, cfg_rd_valid}, {31'h0, v});
        if (v) check("rdata", cfg_rdata, exp_rd);
        check("slot_number", {19'h0, physical_slot_number}, {19'h0, word[31:19]});
        check("scale", {30'h0, power_limit_scale}, {30'h0, word[16:15]});
        check("value", {24'h0, power_limit_value}, {24'h0, word[14:7]});
        check("hotplug", {31'h0, hotplug_capable}, {31'h0, word[6]});
        check("surprise", {31'h0, surprise_removal_flag}, 32'h0000_0000);
        check("pwr_ind", {31'h0, power_indicator_present}, {31'h0, word[4]});
        check("att_ind", {31'h0, attention_indicator_present}, {31'h0, word[3]});
        check("latch", {31'h0, latch_sensor_present}, {31'h0, word[2]});
        check("pwr_ctl", {31'h0, power_controller_present}, {31'h0, word[1]});
        check("att_btn", {31'h0, attention_button_present}, {31'h0, word[0]});
        check("locked", {31'h0, fields_locked}, {31'h0, &lock});
    endtask : check_all

    // One bus cycle; outputs are judged just after the edge that took it
    task automatic op(input logic wr, input logic rd, input logic [11:0] a,
                      input logic [3:0] be, input logic [31:0] wd);
        logic [31:0] lm;
        @(negedge core_clk);
        cfg_wr    = wr;
        cfg_rd    = rd;
        cfg_addr  = a;
        cfg_be    = be;
        cfg_wdata = wd;
        @(posedge core_clk);
        #1;
        lm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        // Read sees the word from before a same-cycle write
        if (rd) exp_rd = (a == `SCAP_OFFSET) ? word : 32'h0000_0000;
        if (wr && a == `SCAP_OFFSET) begin
            for (int i = 0; i < `SCAP_NUM_FIELDS; i++) begin
                if (!lock[i] && (fmask[i] & lm) != 32'h0000_0000) begin
                    word    = (word & ~fmask[i]) | (wd & fmask[i] & lm);
                    lock[i] = 1'b1;
                end
            end
        end
        check_all(rd);
    endtask : op

    task automatic do_reset(input int n);
        @(negedge core_clk);
        rst_b  = 1'b0;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        word   = 32'h0000_0000;
        lock   = 9'h000;
        repeat (n) @(negedge core_clk);
        check_all(1'b0);
        rst_b = 1'b1;
    endtask : do_reset

    initial begin
        core_clk  = 1'b0;
        rst_b     = 1'b0;
        cfg_wr    = 1'b0;
        cfg_rd    = 1'b0;
        cfg_addr  = 12'h000;
        cfg_be    = 4'h0;
        cfg_wdata = 32'h0000_0000;
        failures  = 0;
        n_tests   = 0;
        exp_rd    = 32'h0000_0000;
        void'($urandom(32'h3C16));
        do_reset(12);
        op(1'b0, 1'b1, 12'h080, 4'h0, 32'h0000_0000);
        // Single upper-middle lane: partial slot number and scale lock at once
        op(1'b1, 1'b0, 12'h080, 4'h4, 32'hFFFF_FFFF);
        op(1'b1, 1'b1, 12'h080, 4'hF, 32'hFFFF_FFFF);
        op(1'b1, 1'b1, 12'h080, 4'hF, 32'h0000_0000);
        op(1'b0, 1'b1, 12'h084, 4'h0, 32'h0000_0000);
        do_reset(2);
        // Onboard port: firmware loads slot number zero
        op(1'b1, 1'b0, 12'h080, 4'hF, 32'h0007_A5AA);
        op(1'b1, 1'b1, 12'h080, 4'hF, 32'hFFF8_0000);
        op(1'b0, 1'b1, 12'h080, 4'h0, 32'h0000_0000);
        for (int k = 0; k < 480; k++) begin
            logic [11:0] a;
            if (k % 40 == 0) do_reset(2);
            a = ($urandom % 4 == 0) ? 12'($urandom) : 12'h080;
            op(1'($urandom), 1'($urandom), a, 4'($urandom), $urandom);
        end
        tally_and_finish();
    end

    // About 540 cycles expected; the limit leaves ample margin
    initial begin
        #200_000;
        failures++;
        tally_and_finish();
    end
endmodule : tb_scap_slot_cap

`default_nettype wire
